// file: core/pgc_pkg.sv
// Package with register map, field layout and timing constants of the PWM and I/O configuration block
package pgc_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [6:0] PGC_ADDR_IO_PIN_CONFIG = 7'h17;
  localparam logic [6:0] PGC_ADDR_PWM_ONE_DUTY = 7'h18;
  localparam logic [6:0] PGC_ADDR_PWM_TWO_DUTY = 7'h19;
  localparam logic [6:0] PGC_ADDR_PWM_FREQ_SEL = 7'h1C;
  localparam logic [6:0] PGC_ADDR_HOST_SCRATCH = 7'h1E;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] PGC_RST_BYTE = 8'h00;
  localparam int PGC_POS_FREQ_A = 0;
  localparam int PGC_POS_FREQ_B = 2;
  localparam logic [7:0] PGC_FREQ_MASK = 8'h05;

  // ---------------------------------------------------------------
  // Timing: counter steps and step lengths at 200 MHz
  // ---------------------------------------------------------------
  localparam int PGC_CLK_HZ = 200000000;
  localparam int PGC_PWM_STEPS = 255;
  localparam int PGC_SLOW_HZ = 200;
  localparam int PGC_FAST_HZ = 400;
  localparam int PGC_SLOW_STEP_CYC = PGC_CLK_HZ / (PGC_SLOW_HZ * PGC_PWM_STEPS);
  localparam int PGC_FAST_STEP_CYC = PGC_CLK_HZ / (PGC_FAST_HZ * PGC_PWM_STEPS);
  localparam int PGC_FO_HZ = 200;
  localparam int PGC_FO_PERIOD_CYC = PGC_CLK_HZ / PGC_FO_HZ;
  localparam int PGC_FILT_US = 16;
  localparam int PGC_FILT_CYC = (PGC_FILT_US * (PGC_CLK_HZ / 1000000));

  // ---------------------------------------------------------------
  // I/O pin mode codes
  // ---------------------------------------------------------------
  localparam logic [2:0] PGC_MODE_OFF = 3'h4;
  localparam logic [2:0] PGC_MODE_WAKE = 3'h5;
  localparam logic [2:0] PGC_MODE_LOW_SIDE = 3'h6;
  localparam logic [2:0] PGC_MODE_HIGH_SIDE = 3'h7;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } pgc_req_s;

  typedef struct packed {
    logic fixed_freq_output;
    logic low_side_on;
    logic high_side_on;
    logic wake_enable;
    logic wake_level;
  } pgc_pin_s;

endpackage : pgc_pkg

// file: core/pgc_top.sv
// PWM channels, I/O pin configuration and host scratch byte of the system basis device
`timescale 1ns/1ps
// Summary of operation
// RULE1: Fixed-frequency output duty is 20, 10, 5 or 2.5 percent by two-bit select.
// RULE2: Pin b mode: 0-3 fixed output, 4 off, 5 filtered wake, 6 low, 7 high.
// RULE3: Software assigns the matching timer to a high-side switch when using filters.
// RULE4: Eight-bit duty gives on-time value/255; zero always off, all ones always on.
// RULE5: Very short on-times such as duty one need not be realised by the switch.
// RULE6: Frequency bit 0 channel a, bit 2 channel b; clear 200 Hz, set 400 Hz.
// RULE7: PWM period derives from the internal system clock and shares its tolerance.
// RULE8: Frequency-select reserved bits 7:3 and 1 always read zero.
// RULE9: Scratch byte is written only by the host, never by device logic.
// RULE10: Scratch byte clears on power-up only and survives soft reset.
// RULE11: Scratch byte is not cleared entering fail-safe or restart modes.
// RULE12: Scratch byte is reachable only in normal mode.
// RULE13: High-side code 100 follows channel a, code 101 follows channel b.
// RULE14: Pin a mode is bits 2:0 with the same code set as pin b.
// RULE15: Free-running 255-step counter; new settings take effect at the period boundary.
module pgc_top
  import pgc_pkg::*;
#(
  parameter int STEPS = PGC_PWM_STEPS,
  parameter int SLOW_STEP_CYC = PGC_SLOW_STEP_CYC,
  parameter int FAST_STEP_CYC = PGC_FAST_STEP_CYC,
  parameter int FO_PERIOD_CYC = PGC_FO_PERIOD_CYC,
  parameter int FILT_CYC = PGC_FILT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic por_nrst,
  input wire logic normal_mode,
  input wire pgc_req_s req,
  output logic [7:0] rdata,
  input wire logic [2:0] hs_cfg [4],
  output logic [3:0] hs_pwm_sel,
  output logic [3:0] hs_pwm_drive,
  output logic pulse_channel_a,
  output logic pulse_channel_b,
  input wire logic [1:0] io_pin_in,
  output pgc_pin_s [1:0] io_pin_out
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] duty_a_q, duty_a_d;
  logic [7:0] duty_b_q, duty_b_d;
  logic [7:0] freq_q, freq_d;
  logic [7:0] scratch_q, scratch_d;
  logic [7:0] rdata_d;
  logic [1:0] fixed_out_duty_sel;
  logic [2:0] io_pin_a_mode, io_pin_b_mode;

  assign fixed_out_duty_sel = cfg_q[7:6];
  assign io_pin_b_mode = cfg_q[5:3];
  assign io_pin_a_mode = cfg_q[2:0]; // RULE14

  always_comb begin
    cfg_d = cfg_q;
    duty_a_d = duty_a_q;
    duty_b_d = duty_b_q;
    freq_d = freq_q;
    scratch_d = scratch_q;
    rdata_d = rdata;
    if (req.wr) begin
      case (req.addr)
        PGC_ADDR_IO_PIN_CONFIG: cfg_d = req.wdata;
        PGC_ADDR_PWM_ONE_DUTY: duty_a_d = req.wdata;
        PGC_ADDR_PWM_TWO_DUTY: duty_b_d = req.wdata;
        PGC_ADDR_PWM_FREQ_SEL: freq_d = req.wdata & PGC_FREQ_MASK; // RULE8
        PGC_ADDR_HOST_SCRATCH: begin
          if (normal_mode) begin
            scratch_d = req.wdata; // RULE9 RULE12
          end
        end
        default: ;
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        PGC_ADDR_IO_PIN_CONFIG: rdata_d = cfg_q;
        PGC_ADDR_PWM_ONE_DUTY: rdata_d = duty_a_q;
        PGC_ADDR_PWM_TWO_DUTY: rdata_d = duty_b_q;
        PGC_ADDR_PWM_FREQ_SEL: rdata_d = freq_q & PGC_FREQ_MASK; // RULE8
        PGC_ADDR_HOST_SCRATCH: rdata_d = normal_mode ? scratch_q : PGC_RST_BYTE; // RULE12
        default: rdata_d = PGC_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_q <= PGC_RST_BYTE;
      duty_a_q <= PGC_RST_BYTE;
      duty_b_q <= PGC_RST_BYTE;
      freq_q <= PGC_RST_BYTE;
      rdata <= PGC_RST_BYTE;
    end else begin
      cfg_q <= cfg_d;
      duty_a_q <= duty_a_d;
      duty_b_q <= duty_b_d;
      freq_q <= freq_d;
      rdata <= rdata_d;
    end
  end

  // Scratch byte has its own power-on reset only
  always_ff @(posedge clk) begin
    if (!por_nrst) begin
      scratch_q <= PGC_RST_BYTE; // RULE10 RULE11
    end else begin
      scratch_q <= scratch_d;
    end
  end

  // ---------------------------------------------------------------
  // PWM channels
  // ---------------------------------------------------------------
  logic [7:0] duty_all [2];
  logic [1:0] fsel_all;
  logic [1:0] pwm_out;
  assign duty_all[0] = duty_a_q;
  assign duty_all[1] = duty_b_q;
  assign fsel_all[0] = freq_q[PGC_POS_FREQ_A]; // RULE6
  assign fsel_all[1] = freq_q[PGC_POS_FREQ_B]; // RULE6

  for (genvar ch = 0; ch < 2; ch++) begin : g_pwm
    logic [19:0] pre_q, pre_d;
    logic [7:0] step_q, step_d;
    logic [7:0] act_duty_q, act_duty_d;
    logic act_fast_q, act_fast_d;
    logic out_q, out_d;
    logic [19:0] step_len;
    always_comb begin
      step_len = act_fast_q ? 20'(FAST_STEP_CYC - 1) : 20'(SLOW_STEP_CYC - 1); // RULE7
      pre_d = pre_q + 20'h00001;
      step_d = step_q;
      act_duty_d = act_duty_q;
      act_fast_d = act_fast_q;
      if (pre_q >= step_len) begin
        pre_d = 20'h00000;
        step_d = step_q + 8'h01;
        if (step_q >= 8'(STEPS - 1)) begin
          step_d = 8'h00; // RULE15
          act_duty_d = duty_all[ch]; // RULE15
          act_fast_d = fsel_all[ch]; // RULE15
        end
      end
      // Duty one yields a single step; the switch may not resolve it
      out_d = (step_d < act_duty_d); // RULE4 RULE5
    end
    always_ff @(posedge clk) begin
      if (!nrst) begin
        pre_q <= 20'h00000;
        step_q <= 8'h00;
        act_duty_q <= PGC_RST_BYTE;
        act_fast_q <= 1'b0;
        out_q <= 1'b0;
      end else begin
        pre_q <= pre_d;
        step_q <= step_d;
        act_duty_q <= act_duty_d;
        act_fast_q <= act_fast_d;
        out_q <= out_d;
      end
    end
    assign pwm_out[ch] = out_q;
  end

  assign pulse_channel_a = pwm_out[0];
  assign pulse_channel_b = pwm_out[1];

  // ---------------------------------------------------------------
  // High-side switch PWM selection
  // ---------------------------------------------------------------
  for (genvar hs = 0; hs < 4; hs++) begin : g_hs
    assign hs_pwm_sel[hs] = (hs_cfg[hs] == 3'h4) || (hs_cfg[hs] == 3'h5); // RULE13
    assign hs_pwm_drive[hs] = (hs_cfg[hs] == 3'h4) ? pwm_out[0] :
                              (hs_cfg[hs] == 3'h5) ? pwm_out[1] : 1'b0; // RULE13
  end

  // ---------------------------------------------------------------
  // Fixed-frequency output and I/O pins
  // ---------------------------------------------------------------
  logic [23:0] fo_cnt_q, fo_cnt_d;
  logic [23:0] fo_on_cyc;
  logic fo_q, fo_d;
  always_comb begin
    case (fixed_out_duty_sel)
      2'h0: fo_on_cyc = 24'(FO_PERIOD_CYC / 5); // RULE1
      2'h1: fo_on_cyc = 24'(FO_PERIOD_CYC / 10); // RULE1
      2'h2: fo_on_cyc = 24'(FO_PERIOD_CYC / 20); // RULE1
      default: fo_on_cyc = 24'(FO_PERIOD_CYC / 40); // RULE1
    endcase
    fo_cnt_d = (fo_cnt_q >= 24'(FO_PERIOD_CYC - 1)) ? 24'h000000 : fo_cnt_q + 24'h000001;
    fo_d = fo_cnt_d < fo_on_cyc;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fo_cnt_q <= 24'h000000;
      fo_q <= 1'b0;
    end else begin
      fo_cnt_q <= fo_cnt_d;
      fo_q <= fo_d;
    end
  end

  logic [2:0] pin_mode [2];
  assign pin_mode[0] = io_pin_a_mode;
  assign pin_mode[1] = io_pin_b_mode;

  for (genvar p = 0; p < 2; p++) begin : g_pin
    logic [11:0] filt_q, filt_d;
    logic lvl_q, lvl_d;
    pgc_pin_s o_q, o_d;
    always_comb begin
      filt_d = filt_q;
      lvl_d = lvl_q;
      if (io_pin_in[p] == lvl_q) begin
        filt_d = 12'h000;
      end else if (filt_q >= 12'(FILT_CYC - 1)) begin
        filt_d = 12'h000;
        lvl_d = io_pin_in[p]; // RULE2
      end else begin
        filt_d = filt_q + 12'h001;
      end
      o_d = '0;
      o_d.fixed_freq_output = ~pin_mode[p][2] & fo_q; // RULE2 RULE14
      o_d.low_side_on = (pin_mode[p] == PGC_MODE_LOW_SIDE); // RULE2
      o_d.high_side_on = (pin_mode[p] == PGC_MODE_HIGH_SIDE); // RULE2
      o_d.wake_enable = (pin_mode[p] == PGC_MODE_WAKE); // RULE2
      o_d.wake_level = (pin_mode[p] == PGC_MODE_WAKE) & lvl_d; // RULE2
    end
    always_ff @(posedge clk) begin
      if (!nrst) begin
        filt_q <= 12'h000;
        lvl_q <= 1'b0;
        o_q <= '0;
      end else begin
        filt_q <= filt_d;
        lvl_q <= lvl_d;
        o_q <= o_d;
      end
    end
    assign io_pin_out[p] = o_q;
  end

endmodule : pgc_top

// file: verification/pgc_hs_load.sv
// High-side switch load model counting on-cycles of each driven output
`timescale 1ns/1ps
module pgc_hs_load (
  input wire logic clk,
  input wire logic clr,
  input wire logic win,
  input wire logic [3:0] drive,
  output int unsigned on_cnt [4]
);
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (clr) on_cnt[i] <= 0;
      else if (win && drive[i]) on_cnt[i] <= on_cnt[i] + 1;
    end
  end
endmodule : pgc_hs_load

// file: verification/pgc_top_chk.sv
// Assertion checker for the PWM and I/O configuration block
`timescale 1ns/1ps
module pgc_top_chk
  import pgc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic normal_mode,
  input wire pgc_req_s req,
  input wire logic [7:0] rdata,
  input wire logic [2:0] hs_cfg [4],
  input wire logic [3:0] hs_pwm_sel,
  input wire logic [3:0] hs_pwm_drive,
  input wire logic pulse_channel_a,
  input wire logic pulse_channel_b
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_wr_rd(logic [6:0] a);
    req.wr && !req.rd && normal_mode && req.addr == a ##1 req.rd && !req.wr && normal_mode && req.addr == a;
  endsequence
  for (genvar i = 0; i < 4; i++) begin : g_hs
    a_sel_decode: assert property (hs_pwm_sel[i] == (hs_cfg[i] inside {3'h4, 3'h5}))
      else $error("switch select wrong");
    a_drive_chan_a: assert property (hs_cfg[i] == 3'h4 |-> hs_pwm_drive[i] == pulse_channel_a)
      else $error("switch not on channel a");
    a_drive_chan_b: assert property (hs_cfg[i] == 3'h5 |-> hs_pwm_drive[i] == pulse_channel_b)
      else $error("switch not on channel b");
    a_drive_off: assert property (!(hs_cfg[i] inside {3'h4, 3'h5}) |-> !hs_pwm_drive[i])
      else $error("switch driven without pwm code");
  end
  a_freq_resv: assert property (req.rd && req.addr == PGC_ADDR_PWM_FREQ_SEL |=> (rdata & ~PGC_FREQ_MASK) == 8'h00)
    else $error("reserved frequency bits set");
  a_scratch_gate: assert property (req.rd && req.addr == PGC_ADDR_HOST_SCRATCH && !normal_mode |=> rdata == 8'h00)
    else $error("scratch readable outside normal mode");
  a_unmapped_rd: assert property (req.rd && !(req.addr inside {7'h17, 7'h18, 7'h19, 7'h1C, 7'h1E}) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reset_pwm: assert property (disable iff (1'b0) !nrst |=> !pulse_channel_a && !pulse_channel_b)
    else $error("pwm active in reset");
  a_duty_readback: assert property (s_wr_rd(PGC_ADDR_PWM_ONE_DUTY) |=> rdata == $past(req.wdata, 2))
    else $error("duty readback wrong");
  a_scratch_keep: assert property (s_wr_rd(PGC_ADDR_HOST_SCRATCH) |=> rdata == $past(req.wdata, 2))
    else $error("scratch readback wrong");
endmodule : pgc_top_chk

bind pgc_top pgc_top_chk pgc_top_chk_i (.clk(clk), .nrst(nrst), .normal_mode(normal_mode), .req(req),
  .rdata(rdata), .hs_cfg(hs_cfg), .hs_pwm_sel(hs_pwm_sel), .hs_pwm_drive(hs_pwm_drive),
  .pulse_channel_a(pulse_channel_a), .pulse_channel_b(pulse_channel_b));

// file: verification/tb.sv
// Self-checking testbench for the PWM and I/O configuration block
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import pgc_pkg::*;
  typedef struct {logic [6:0] a; logic [7:0] w; logic [7:0] e;} pgc_row_s;
  logic clk = 0, nrst = 0, por_nrst = 0, normal_mode = 1, win = 0, clr = 0;
  pgc_req_s req = '0;
  logic [7:0] rdata, d;
  logic [2:0] hs_cfg [4] = '{3'h4, 3'h5, 3'h0, 3'h4};
  logic [3:0] hs_pwm_sel, hs_pwm_drive;
  logic pulse_channel_a, pulse_channel_b;
  logic [1:0] io_pin_in = 2'h0;
  pgc_pin_s [1:0] io_pin_out;
  int unsigned on_cnt [4];
  int n_fail = 0, total_checks = 0, cyc = 0;
  pgc_row_s rows [6] = '{'{7'h17, 8'hAA, 8'hAA}, '{7'h18, 8'h80, 8'h80}, '{7'h19, 8'hFF, 8'hFF},
    '{7'h1C, 8'hFF, 8'h05}, '{7'h1E, 8'h5A, 8'h5A}, '{7'h1A, 8'h33, 8'h00}};
  logic [7:0] da [3] = '{8'h80, 8'h00, 8'h01}, db [3] = '{8'h40, 8'hFF, 8'h01}, fr [3] = '{8'h04, 8'h01, 8'h00};
  int ea [3] = '{512, 0, 4}, eb [3] = '{256, 1020, 4}, efo [4] = '{16, 8, 4, 2};
  pgc_pin_s pin_exp [4] = '{5'h00, 5'h02, 5'h08, 5'h04};
  always #2.5 clk = ~clk;
  pgc_top #(.SLOW_STEP_CYC(4), .FAST_STEP_CYC(2), .FO_PERIOD_CYC(80), .FILT_CYC(4)) pgc_top_i (.clk(clk),
    .nrst(nrst), .por_nrst(por_nrst), .normal_mode(normal_mode), .req(req), .rdata(rdata), .hs_cfg(hs_cfg),
    .hs_pwm_sel(hs_pwm_sel), .hs_pwm_drive(hs_pwm_drive), .pulse_channel_a(pulse_channel_a),
    .pulse_channel_b(pulse_channel_b), .io_pin_in(io_pin_in), .io_pin_out(io_pin_out));
  pgc_hs_load pgc_hs_load_i (.clk(clk), .clr(clr), .win(win),
    .drive({io_pin_out[1].fixed_freq_output, hs_pwm_drive[2:0]}), .on_cnt(on_cnt));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task fin(input string s);
    $display("test %s done", s);
  endtask : fin
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task wr(input logic [6:0] a, input logic [7:0] w);
    @(posedge clk) req <= {1'b1, 1'b0, a, w};
    @(posedge clk) req <= '0;
  endtask : wr
  task rd(input logic [6:0] a);
    @(posedge clk) req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk) req <= '0;
    #1 d = rdata;
  endtask : rd
  task wr_rd(input logic [6:0] a, input logic [7:0] w);
    @(posedge clk) req <= {1'b1, 1'b0, a, w};
    rd(a);
  endtask : wr_rd
  task measure(input int n);
    @(posedge clk) clr <= 1;
    @(posedge clk) begin
      clr <= 0;
      win <= 1;
    end
    wt(n);
    win <= 0;
    #1;
  endtask : measure
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    wt(16);
    nrst <= 1;
    por_nrst <= 1;
    foreach (rows[k]) begin
      wr_rd(rows[k].a, rows[k].w);
      `CHK(d, rows[k].e)
    end
    fin("regs");
    @(posedge clk) normal_mode <= 0;
    wr(7'h1E, 8'h77);
    rd(7'h1E);
    `CHK(d, 8'h00)
    @(posedge clk) normal_mode <= 1;
    rd(7'h1E);
    `CHK(d, 8'h5A)
    fin("gate");
    @(posedge clk) nrst <= 0;
    @(posedge clk) nrst <= 1;
    rd(7'h18);
    `CHK(d, 8'h00)
    rd(7'h1C);
    `CHK(d, 8'h00)
    rd(7'h1E);
    `CHK(d, 8'h5A)
    @(posedge clk) begin
      nrst <= 0;
      por_nrst <= 0;
    end
    @(posedge clk) begin
      nrst <= 1;
      por_nrst <= 1;
    end
    rd(7'h1E);
    `CHK(d, 8'h00)
    fin("reset");
    for (int k = 0; k < 3; k++) begin
      wr(7'h18, da[k]);
      wr(7'h19, db[k]);
      wr(7'h1C, fr[k]);
      wt(1100);
      measure(1020);
      `CHK(on_cnt[0], ea[k])
      `CHK(on_cnt[1], eb[k])
      `CHK(on_cnt[2], 0)
    end
    fin("pwm");
    for (int s = 0; s < 4; s++) begin
      wr(7'h17, {s[1:0], 3'b000, 3'b100});
      wt(100);
      measure(80);
      `CHK(on_cnt[3], efo[s])
    end
    fin("fixed");
    for (int m = 4; m < 8; m++) begin
      wr(7'h17, {2'b00, m[2:0], m[2:0]});
      wt(3);
      #1;
      `CHK(io_pin_out[0], pin_exp[m - 4])
      `CHK(io_pin_out[1], pin_exp[m - 4])
    end
    @(posedge clk) hs_cfg[2] <= 3'h2;
    wr(7'h17, 8'h2D);
    @(posedge clk) io_pin_in <= 2'h3;
    wt(2);
    #1;
    `CHK(io_pin_out[1].wake_level, 1'b0)
    `CHK(hs_pwm_sel[2], 1'b0)
    wt(10);
    #1;
    `CHK(io_pin_out[1].wake_level, 1'b1)
    fin("pins");
    print_verdict();
  end
endmodule : tb
